//--- core/mshl_top.sv
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "mshl_consts.svh"

// What this block does
// R1: Service request pin low while message pending
// R2: Handshakes high permit, low halt sending
// R3: Data lines inverted; zero drives high
// R4: Power-on 9600 8N1 with flow control
// R5: Rate, flow, parity changed separately by command; here flow and parity share the control offset and are written together
// R6: Standard rates 110 through 38400
// R7: Four extended rates above 38400
// R8: Optional 10 MHz reference, never required
// R9: Frame start, data LSB first, parity, stop

module mshl_top (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Serial link pins, physical levels
	input wire logic host_txd,
	output logic host_rxd,
	input wire logic host_rts,
	output logic dev_cts,
	output logic status_n,
	// Optional reference pair
	input wire logic ref_clock_pos,
	input wire logic ref_clock_neg,
	// Interrupt
	output logic irq
);
	import mshl_pkg::*;

	// ----------------------------------------
	// Registers and state
	// ----------------------------------------
	logic flow_en;
	mshl_par_t par_mode;
	logic sreq;
	logic [3:0] rate_sel;
	logic [4:0] stat;
	logic [4:0] mask;
	logic [7:0] rx_hold;
	logic rx_full;
	logic tx_req;
	logic [7:0] tx_byte;
	logic ph_write;
	logic [11:0] ph_addr;
	logic addr_ok;
	logic wr_en;
	logic rate_chg;
	logic tick16;
	logic tx_line;
	logic tx_busy;
	logic tx_done;
	logic rx_done;
	logic [7:0] rx_byte;
	logic rx_perr;
	logic rx_ferr;
	logic [4:0] events;
	logic rx_take;
	logic [31:0] next_rdata;

	// ----------------------------------------
	// AHB-Lite address phase capture
	// ----------------------------------------
	// Latches a valid write address for the following data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_write <= 1'b0;
			ph_addr <= 12'h000;
		end else if (hready) begin
			ph_write <= hsel && htrans[1] && hwrite;
			ph_addr <= haddr;
		end
	end

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_ok = hsel && htrans[1] && hready;
	assign wr_en = ph_write;
	assign rate_chg = wr_en && ph_addr == `MSHL_OFS_BAUD;

	// Read data mux, registered at the address phase
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (haddr == `MSHL_OFS_CTRL) begin
			next_rdata = {28'h0000000, sreq, par_mode, flow_en};
		end else if (haddr == `MSHL_OFS_BAUD) begin
			next_rdata = {28'h0000000, rate_sel};
		end else if (haddr == `MSHL_OFS_STAT) begin
			next_rdata = {27'h0000000, stat};
		end else if (haddr == `MSHL_OFS_MASK) begin
			next_rdata = {27'h0000000, mask};
		end else if (haddr == `MSHL_OFS_TXD) begin
			next_rdata = {23'h000000, tx_req || tx_busy, tx_byte};
		end else if (haddr == `MSHL_OFS_RXD) begin
			next_rdata = {23'h000000, rx_full, rx_hold};
		end else if (haddr == `MSHL_OFS_LINE) begin
			next_rdata = {28'h0000000, ref_clock_pos, ref_clock_neg, !host_rts, dev_cts};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_ok && !hwrite) begin
			hrdata <= next_rdata;
		end
	end

	// Reading the receive holding register frees it
	assign rx_take = addr_ok && !hwrite && haddr == `MSHL_OFS_RXD;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	// Rate has its own offset; flow, parity and sreq share the control offset and are written together
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flow_en <= 1'(`MSHL_CTRL_RST & 4'h1); // R4
			par_mode <= MSHL_PAR_NONE; // R4
			sreq <= 1'b0;
		end else if (wr_en && ph_addr == `MSHL_OFS_CTRL) begin
			flow_en <= hwdata[`MSHL_CTRL_FLOW]; // R5
			par_mode <= mshl_par_t'(hwdata[`MSHL_CTRL_PAR_HI:`MSHL_CTRL_PAR_LO]); // R5
			sreq <= hwdata[`MSHL_CTRL_SREQ];
		end
	end

	// Rate index, default 9600; out-of-table values are refused
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rate_sel <= `MSHL_BAUD_RST; // R4
		end else if (rate_chg && hwdata[3:0] < 4'(`MSHL_NBAUD)) begin
			rate_sel <= hwdata[3:0]; // R5 R6 R7
		end
	end

	// ----------------------------------------
	// Transmit request holding
	// ----------------------------------------
	// Software write queues one byte; ignored while a byte is pending
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_req <= 1'b0;
			tx_byte <= 8'h00;
		end else if (wr_en && ph_addr == `MSHL_OFS_TXD && !tx_req && !tx_busy) begin
			tx_req <= 1'b1;
			tx_byte <= hwdata[7:0];
		end else if (tx_busy) begin
			tx_req <= 1'b0;
		end
	end

	// ----------------------------------------
	// Bit-rate divider and framers
	// ----------------------------------------
	mshl_tick u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.rate_sel(rate_sel),
		.restart(rate_chg),
		.tick16(tick16)
	);

	// With flow control on, starts a character only while the host holds its handshake high
	mshl_frame #(.IS_TX(1'b1)) u_tx (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick16(tick16),
		.par_mode(par_mode),
		.start(tx_req),
		.din(tx_byte),
		.allow(!flow_en || host_rts), // R2
		.ser_in(1'b1),
		.ser_out(tx_line),
		.busy(tx_busy),
		.done(tx_done),
		.dout(),
		.par_err(),
		.frm_err()
	);

	// Receive line is inverted back to logic level
	mshl_frame #(.IS_TX(1'b0)) u_rx (
		.hclk(hclk),
		.hresetn(hresetn),
		.tick16(tick16),
		.par_mode(par_mode),
		.start(1'b0),
		.din(8'h00),
		.allow(1'b1),
		.ser_in(!host_txd), // R3
		.ser_out(),
		.busy(),
		.done(rx_done),
		.dout(rx_byte),
		.par_err(rx_perr),
		.frm_err(rx_ferr)
	);

	// Output line inverted: logic zero is the high level
	assign host_rxd = !tx_line; // R3

	// ----------------------------------------
	// Receive holding and flow control
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_hold <= 8'h00;
			rx_full <= 1'b0;
		end else if (rx_done) begin
			rx_hold <= rx_byte;
			rx_full <= 1'b1;
		end else if (rx_take) begin
			rx_full <= 1'b0;
		end
	end

	// With flow control on, halt the host while the holding register is occupied
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dev_cts <= 1'b0;
		end else begin
			dev_cts <= !flow_en || !rx_full; // R2
		end
	end

	// ----------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------
	assign events = {rx_done && rx_full && !rx_take, rx_done && rx_ferr, rx_done && rx_perr, tx_done, rx_done};

	// Sticky bits, write one to clear, new events win
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stat <= 5'h00;
		end else if (wr_en && ph_addr == `MSHL_OFS_STAT) begin
			stat <= (stat & ~hwdata[4:0]) | events;
		end else begin
			stat <= stat | events;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mask <= 5'h00;
		end else if (wr_en && ph_addr == `MSHL_OFS_MASK) begin
			mask <= hwdata[4:0];
		end
	end

	// Interrupt and service request both follow pending status
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
			status_n <= 1'b1;
		end else begin
			irq <= |(stat & mask);
			status_n <= !(sreq || |(stat & mask)); // R1
		end
	end

	// The reference pair is only observed; nothing depends on it
	// R8
endmodule

//--- shared/mshl_consts.svh
`ifndef MSHL_CONSTS_SVH
`define MSHL_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MSHL_OFS_CTRL 12'h000
`define MSHL_OFS_BAUD 12'h004
`define MSHL_OFS_STAT 12'h008
`define MSHL_OFS_MASK 12'h00C
`define MSHL_OFS_TXD 12'h010
`define MSHL_OFS_RXD 12'h014
`define MSHL_OFS_LINE 12'h018

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MSHL_CTRL_FLOW 0
`define MSHL_CTRL_PAR_LO 1
`define MSHL_CTRL_PAR_HI 2
`define MSHL_CTRL_SREQ 3
`define MSHL_ST_RXDONE 0
`define MSHL_ST_TXDONE 1
`define MSHL_ST_PARERR 2
`define MSHL_ST_FRMERR 3
`define MSHL_ST_OVRUN 4

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define MSHL_CTRL_RST 4'h1
`define MSHL_BAUD_RST 4'h5
`define MSHL_CLK_HZ 20000000
`define MSHL_NBAUD 12

`endif

//--- shared/mshl_pkg.sv
package mshl_pkg;
	// Parity selection
	typedef enum logic [1:0] {
		MSHL_PAR_NONE = 2'b00,
		MSHL_PAR_ODD = 2'b01,
		MSHL_PAR_EVEN = 2'b10,
		MSHL_PAR_MARK = 2'b11
	} mshl_par_t;
	// Frame walker states
	typedef enum logic [2:0] {
		MSHL_IDLE = 3'b000,
		MSHL_START = 3'b001,
		MSHL_DATA = 3'b010,
		MSHL_PARITY = 3'b011,
		MSHL_STOP = 3'b100
	} mshl_state_t;
endpackage

//--- core/mshl_tick.sv
`timescale 1ns/1ps
`include "mshl_consts.svh"

// 16x oversample enable from the selected rate index
module mshl_tick (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Rate index and clear
	input wire logic [3:0] rate_sel,
	input wire logic restart,
	// Enable out
	output logic tick16
);
	logic [15:0] count;
	logic [15:0] limit;

	// Divisor table, sixteen ticks per bit at 20 MHz
	always_comb begin
		case (rate_sel)
			4'h0: limit = 16'(`MSHL_CLK_HZ / (110 * 16) - 1);
			4'h1: limit = 16'(`MSHL_CLK_HZ / (300 * 16) - 1);
			4'h2: limit = 16'(`MSHL_CLK_HZ / (1200 * 16) - 1);
			4'h3: limit = 16'(`MSHL_CLK_HZ / (2400 * 16) - 1);
			4'h4: limit = 16'(`MSHL_CLK_HZ / (4800 * 16) - 1);
			4'h5: limit = 16'(`MSHL_CLK_HZ / (9600 * 16) - 1);
			4'h6: limit = 16'(`MSHL_CLK_HZ / (19200 * 16) - 1);
			4'h7: limit = 16'(`MSHL_CLK_HZ / (38400 * 16) - 1);
			4'h8: limit = 16'(`MSHL_CLK_HZ / (62500 * 16) - 1);
			4'h9: limit = 16'(`MSHL_CLK_HZ / (78125 * 16) - 1);
			4'hA: limit = 16'(`MSHL_CLK_HZ / (104167 * 16) - 1);
			4'hB: limit = 16'(`MSHL_CLK_HZ / (156250 * 16) - 1);
			// Only the four extended rates exist above 38400
			default: limit = 16'(`MSHL_CLK_HZ / (9600 * 16) - 1);
		endcase
	end

	// Free-running divider
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			count <= 16'h0000;
			tick16 <= 1'b0;
		end else if (restart || count >= limit) begin
			count <= 16'h0000;
			tick16 <= !restart;
		end else begin
			count <= count + 16'h0001;
			tick16 <= 1'b0;
		end
	end
endmodule

//--- core/mshl_frame.sv
`timescale 1ns/1ps

// One direction of character framing, transmit or receive
module mshl_frame #(
	parameter bit IS_TX = 1'b1
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tick16,
	// Format
	input wire mshl_pkg::mshl_par_t par_mode,
	// Transmit side
	input wire logic start,
	input wire logic [7:0] din,
	input wire logic allow,
	// Serial in, logic level
	input wire logic ser_in,
	// Serial out, logic level
	output logic ser_out,
	output logic busy,
	output logic done,
	output logic [7:0] dout,
	output logic par_err,
	output logic frm_err
);
	import mshl_pkg::*;
	mshl_state_t state;
	logic [3:0] phase;
	logic [2:0] bitn;
	logic [7:0] shift;
	logic par_bit;

	// Parity of the held byte for the chosen mode
	always_comb begin
		case (par_mode)
			MSHL_PAR_ODD: par_bit = ~^shift;
			MSHL_PAR_EVEN: par_bit = ^shift;
			default: par_bit = 1'b1;
		endcase
	end

	assign busy = (state != MSHL_IDLE);

	// Start, data LSB first, optional parity, stop
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= MSHL_IDLE;
			phase <= 4'h0;
			bitn <= 3'h0;
			shift <= 8'h00;
			ser_out <= 1'b1;
			done <= 1'b0;
			dout <= 8'h00;
			par_err <= 1'b0;
			frm_err <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				MSHL_IDLE: begin
					phase <= 4'h0;
					ser_out <= 1'b1;
					if (IS_TX && start && allow) begin // R2
						shift <= din;
						state <= MSHL_START;
					end else if (!IS_TX && !ser_in && tick16) begin
						state <= MSHL_START;
					end
				end
				MSHL_START: if (tick16) begin
					phase <= phase + 4'h1;
					if (IS_TX) ser_out <= 1'b0;
					if (!IS_TX && phase == 4'h7 && ser_in) state <= MSHL_IDLE;
					if (phase == 4'hF) begin
						bitn <= 3'h0;
						state <= MSHL_DATA;
					end
				end
				MSHL_DATA: if (tick16) begin
					phase <= phase + 4'h1;
					if (IS_TX) ser_out <= shift[bitn];
					if (!IS_TX && phase == 4'h7) shift[bitn] <= ser_in; // R9
					if (phase == 4'hF) begin
						bitn <= bitn + 3'h1;
						if (bitn == 3'h7) state <= (par_mode == MSHL_PAR_NONE) ? MSHL_STOP : MSHL_PARITY;
					end
				end
				MSHL_PARITY: if (tick16) begin
					phase <= phase + 4'h1;
					if (IS_TX) ser_out <= par_bit;
					if (!IS_TX && phase == 4'h7) par_err <= (ser_in != par_bit);
					if (phase == 4'hF) state <= MSHL_STOP;
				end
				MSHL_STOP: if (tick16) begin
					phase <= phase + 4'h1;
					if (IS_TX) ser_out <= 1'b1;
					if (!IS_TX && phase == 4'h7) begin
						frm_err <= !ser_in;
						if (par_mode == MSHL_PAR_NONE) par_err <= 1'b0;
						dout <= shift;
						done <= 1'b1;
						state <= MSHL_IDLE;
					end
					if (IS_TX && phase == 4'hF) begin
						done <= 1'b1;
						state <= MSHL_IDLE;
					end
				end
				default: state <= MSHL_IDLE;
			endcase
		end
	end
endmodule

//--- tb/mshl_assertions.sv
`timescale 1ns/1ps

// Port-level checks of the serial host link
module mshl_assertions (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	// Link
	input wire logic host_txd,
	input wire logic host_rxd,
	input wire logic host_rts,
	input wire logic dev_cts,
	input wire logic status_n,
	input wire logic ref_clock_pos,
	input wire logic ref_clock_neg,
	input wire logic irq
);
	logic wr_seen;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Read address phase taken
	sequence s_rd;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	// First edge after reset release
	sequence s_boot;
		$rose(hresetn);
	endsequence
	// Marks any write since reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_seen <= 1'h0;
		end else if (hsel && htrans[1] && hready && hwrite) begin
			wr_seen <= 1'h1;
		end
	end
	a_rxd_boot_idle: assert property (s_boot |-> !host_rxd) else $error("rxd not idle");
	a_cts_boot_on: assert property (s_boot |=> dev_cts) else $error("cts not raised");
	a_sreq_boot_idle: assert property (s_boot |=> status_n) else $error("early request");
	a_irq_sreq_low: assert property ($rose(irq) |-> ##[0:1] !status_n)
		else $error("irq without request");
	a_ctrl_boot_val: assert property (s_rd ##0 (!wr_seen && haddr == 12'h000) |=> hrdata[2:0] == 3'h1)
		else $error("ctrl default wrong");
	a_baud_boot_val: assert property (s_rd ##0 (!wr_seen && haddr == 12'h004) |=> hrdata[3:0] == 4'h5)
		else $error("baud default wrong");
	a_line_cts_echo: assert property (s_rd ##0 haddr == 12'h018 |=> hrdata[0] == $past(dev_cts))
		else $error("line cts wrong");
	a_rdata_hold: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
		else $error("read data moved");
endmodule

bind mshl_top mshl_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
	.hready, .hrdata, .hreadyout, .hresp, .host_txd, .host_rxd, .host_rts, .dev_cts, .status_n,
	.ref_clock_pos, .ref_clock_neg, .irq);

//--- tb/mshl_host.sv
`timescale 1ns/1ps

// Host end of the serial link
module mshl_host (
	// Clock
	input wire logic hclk,
	// Link pins
	input wire logic host_rxd,
	input wire logic dev_cts,
	output logic host_txd,
	output logic host_rts,
	output logic ref_clock_pos,
	output logic ref_clock_neg
);
	int bit_cyc = 2080; // 9600 baud at 16 x 130 cycles
	int nrx = 0;
	logic ref_on = 1'h0;
	logic [10:0] got;
	// Idle levels
	initial begin
		host_txd = 1'h0;
		host_rts = 1'h1;
		ref_clock_pos = 1'h0;
	end
	// Optional 10 MHz pair, quiet when off
	always #50 ref_clock_pos = ref_on & ~ref_clock_pos;
	assign ref_clock_neg = ~ref_clock_pos;
	// Start bit then n bits LSB first, only while cleared
	task automatic send(input logic [9:0] b, input int n);
		wait (dev_cts === 1'h1);
		@(posedge hclk);
		host_txd <= 1'h1;
		for (int i = 0; i < n; i++) begin
			repeat (bit_cyc) @(posedge hclk);
			host_txd <= ~b[i];
		end
		repeat (bit_cyc) @(posedge hclk);
		host_txd <= 1'h0;
		repeat (bit_cyc) @(posedge hclk);
	endtask
	// Samples eleven slots mid-bit after each start
	always begin
		@(posedge host_rxd);
		repeat (bit_cyc / 2) @(posedge hclk);
		for (int i = 0; i < 11; i++) begin
			repeat (bit_cyc) @(posedge hclk);
			got[i] = ~host_rxd;
		end
		nrx++;
	end
endmodule

//--- tb/mshl_top_test.sv
`timescale 1ns/1ps

// Bench of the serial host link
module mshl_top_test;
	logic hclk = 1'h0;
	logic hresetn = 1'h0;
	logic hsel = 1'h0;
	logic hwrite = 1'h0;
	logic [11:0] haddr = 12'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready, hreadyout, hresp, host_txd, host_rxd, host_rts, dev_cts, status_n, irq;
	logic ref_clock_pos, ref_clock_neg;
	int err_total = 0;
	int num_checks = 0;
	// Clock and ready loop-back
	always #25 hclk = ~hclk;
	assign hready = hreadyout;
	mshl_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .host_txd, .host_rxd, .host_rts, .dev_cts, .status_n, .ref_clock_pos,
		.ref_clock_neg, .irq);
	mshl_host host_u (.hclk, .host_rxd, .dev_cts, .host_txd, .host_rts, .ref_clock_pos, .ref_clock_neg);
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// One single transfer, address then data phase
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'h1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'h1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'h1, a, d, x);
	endtask
	task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] x;
		bus(1'h0, a, 32'h0, x);
		chk(n, e, x & m);
	endtask
	task automatic wait_rx(input int n0);
		for (int i = 0; i < 30000 && host_u.nrx == n0; i++) @(posedge hclk);
	endtask
	task automatic tx(input logic [7:0] d, input logic [9:0] e);
		int n0;
		n0 = host_u.nrx;
		wr(12'h010, {24'h0, d});
		wait_rx(n0);
		chk("frame", {22'h0, e}, {22'h0, host_u.got[9:0]});
	endtask
	task automatic rx(input logic [9:0] b, input int n, input logic [31:0] m);
		host_u.send(b, n);
		for (int i = 0; i < 300 && irq !== 1'h1; i++) @(posedge hclk);
		rdc("stat", 12'h008, m, m);
	endtask
	task automatic t_reset;
		rdc("ctrl", 12'h000, 32'hF, 32'h1);
		rdc("baud", 12'h004, 32'hF, 32'h5);
		rdc("line", 12'h018, 32'h1, 32'h1);
		chk("sreq", 32'h1, status_n);
		chk("rxd idle", 32'h0, host_rxd);
		wr(12'h01C, 32'hFF);
		rdc("unmapped", 12'h01C, 32'hFFFFFFFF, 32'h0);
		for (int i = 0; i < 14; i++) begin
			wr(12'h004, i);
			rdc("rate", 12'h004, 32'hF, (i < 12) ? i : 11);
		end
		wr(12'h004, 32'h5);
	endtask
	task automatic t_tx;
		logic p;
		tx(8'hA5, 10'h3A5);
		wr(12'h004, 32'hB);
		host_u.bit_cyc = 128;
		for (int m = 0; m < 4; m++) begin
			p = (m == 1) ? ~^8'h5C : (m == 2) ? ^8'h5C : 1'h1;
			wr(12'h000, 32'h1 | (m << 1));
			tx(8'h5C, {1'h1, p, 8'h5C});
		end
		rdc("tx done", 12'h008, 32'h2, 32'h2);
		wr(12'h008, 32'h1F);
	endtask
	task automatic t_rx;
		host_u.ref_on = 1'h1;
		wr(12'h00C, 32'h1F);
		wr(12'h000, 32'h1);
		rx({2'h3, 8'h3C}, 9, 32'h1);
		chk("cts full", 32'h0, dev_cts);
		chk("sreq", 32'h0, status_n);
		rdc("rxd", 12'h014, 32'h1FF, 32'h13C);
		wr(12'h008, 32'h1F);
		repeat (2) @(posedge hclk);
		chk("cts free", 32'h1, dev_cts);
		chk("irq clear", 32'h0, irq);
		wr(12'h000, 32'h5);
		rx({1'h1, ~^8'h3C, 8'h3C}, 10, 32'h4);
		rdc("rxd", 12'h014, 32'hFF, 32'h3C);
		wr(12'h008, 32'h1F);
		wr(12'h000, 32'h1);
		rx({2'h0, 8'h81}, 9, 32'h8);
		rdc("rxd", 12'h014, 32'hFF, 32'h81);
		wr(12'h008, 32'h1F);
		host_u.ref_on = 1'h0;
	endtask
	task automatic t_flow;
		int n0;
		n0 = host_u.nrx;
		host_u.host_rts <= 1'h0;
		wr(12'h010, 32'h66);
		repeat (400) @(posedge hclk);
		chk("held", 32'h0, host_rxd);
		host_u.host_rts <= 1'h1;
		wait_rx(n0);
		chk("released", 32'h366, {22'h0, host_u.got[9:0]});
		wr(12'h000, 32'h0);
		host_u.host_rts <= 1'h0;
		tx(8'h99, 10'h399);
		host_u.host_rts <= 1'h1;
		wr(12'h000, 32'h1);
	endtask
	task automatic t_irq;
		wr(12'h00C, 32'h0);
		wr(12'h008, 32'h1F);
		tx(8'h0F, 10'h30F);
		chk("irq masked", 32'h0, irq);
		chk("sreq masked", 32'h1, status_n);
		wr(12'h00C, 32'h2);
		repeat (2) @(posedge hclk);
		chk("sreq", 32'h0, status_n);
		wr(12'h008, 32'h2);
		repeat (2) @(posedge hclk);
		chk("irq clear", 32'h0, irq);
		wr(12'h000, 32'h9);
		repeat (2) @(posedge hclk);
		chk("sreq cmd", 32'h0, status_n);
		wr(12'h000, 32'h1);
		repeat (2) @(posedge hclk);
		chk("sreq idle", 32'h1, status_n);
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Watchdog over the whole run
	initial begin
		#4000000;
		err_total++;
		print_verdict;
	end
	// Reset, then the scenarios
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		t_reset;
		t_tx;
		t_rx;
		t_flow;
		t_irq;
		print_verdict;
	end
endmodule
